/* verilog/ufc_top.sv */
// fifo control, register port and dma ready pins for one uart channel
//
// Contract
// - receive interrupt at trigger, keep filling
// - trigger select gives 1, 4, 8, 14
// - control bits five and four read zero
// - bit three picks ready mode
// - mode 0 tx ready low when empty
// - mode 0 rx ready low while data held
// - mode 1 tx ready high only when full
// - mode 1 rx ready low trigger/timeout until empty
// - bit two flushes tx fifo, self clears
// - bit one flushes rx fifo, self clears
// - bit zero enables both fifos
// - other bits written only with bit zero
// - all control fields zero after reset
// - interrupt withdrawn below trigger level (with fifos off it is raised for any held character)
//
// Added by the designer: the address map and the strobed register port.
`timescale 1ns/1ps
module ufc_top #(
   parameter int DEPTH = ufc_pkg::UFC_DEPTH
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // register port
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // transmit shifter side
   output logic [7:0] tx_char,
   output logic tx_char_valid,
   input wire logic tx_char_take,
   // receive shifter side
   input wire logic [7:0] rx_char,
   input wire logic rx_char_valid,
   input wire logic rx_timeout,
   output logic rx_overrun,
   // receive interrupt
   input wire logic rx_int_enable,
   output logic rx_data_int,
   // dma ready pins
   output logic tx_ready_n,
   output logic rx_ready_n
);
   localparam int CW = $clog2(DEPTH + 1);

   typedef struct packed {
      logic [1:0] trig;
      logic mode;
      logic en;
      logic tx_flush;
      logic rx_flush;
      logic [7:0] rdata;
      ufc_pkg::ufc_rx_state_t rx_st;
      logic tx_rdy_n;
      logic rx_rdy_n;
      logic overrun;
   } ufc_top_st_t;

   ufc_top_st_t st_reg;
   ufc_top_st_t st_next;
   logic ctrl_wr;
   logic data_wr;
   logic data_rd;
   logic at_trigger;
   logic block_mode;
   logic [7:0] ctrl_view;

   ufc_fifo_if #(.W(8), .D(DEPTH)) txf ();
   ufc_fifo_if #(.W(8), .D(DEPTH)) rxf ();

   ufc_fifo #(.W(8), .D(DEPTH)) u_tx_fifo (
      .sys_clk(sys_clk),
      .rst(rst),
      .f(txf)
   );
   ufc_fifo #(.W(8), .D(DEPTH)) u_rx_fifo (
      .sys_clk(sys_clk),
      .rst(rst),
      .f(rxf)
   );

   ufc_rx_trigger u_rx_trigger (
      .sys_clk(sys_clk),
      .rst(rst),
      .fifo_en(st_reg.en),
      .rx_trigger_select(st_reg.trig),
      .rx_int_enable(rx_int_enable),
      .rxf(rxf),
      .at_trigger(at_trigger),
      .rx_data_int(rx_data_int)
   );

   assign ctrl_wr = reg_wr && (reg_addr == ufc_pkg::UFC_OFS_CTRL);
   assign data_wr = reg_wr && (reg_addr == ufc_pkg::UFC_OFS_DATA);
   assign data_rd = reg_rd && (reg_addr == ufc_pkg::UFC_OFS_DATA);
   assign block_mode = st_reg.mode && st_reg.en;

   // host writes fill the transmit side
   assign txf.push = data_wr;
   assign txf.push_data = reg_wdata;
   assign txf.pop = tx_char_take;
   assign txf.flush = st_reg.tx_flush;
   // disabled fifos act as holding registers
   assign txf.one_deep = !st_reg.en;

   assign rxf.push = rx_char_valid;
   assign rxf.push_data = rx_char;
   assign rxf.pop = data_rd;
   assign rxf.flush = st_reg.rx_flush;
   assign rxf.one_deep = !st_reg.en;

   // tx head leaves straight from the storage flops
   assign tx_char = txf.head;
   assign tx_char_valid = !txf.empty;
   assign reg_rdata = st_reg.rdata;
   assign tx_ready_n = st_reg.tx_rdy_n;
   assign rx_ready_n = st_reg.rx_rdy_n;
   assign rx_overrun = st_reg.overrun;

   // unused bits and flush bits read zero
   always_comb begin
      ctrl_view = 8'h00;
      ctrl_view[ufc_pkg::UFC_CTRL_TRIG_HI:ufc_pkg::UFC_CTRL_TRIG_LO] =
         st_reg.trig;
      ctrl_view[ufc_pkg::UFC_CTRL_MODE] = st_reg.mode;
      ctrl_view[ufc_pkg::UFC_CTRL_EN] = st_reg.en;
   end

   always_comb begin
      st_next = st_reg;
      st_next.tx_flush = 1'b0;
      st_next.rx_flush = 1'b0;
      st_next.overrun = rx_char_valid && rxf.full;

      // control write
      if (ctrl_wr) begin
         st_next.en = reg_wdata[ufc_pkg::UFC_CTRL_EN];
         // other fields only with enable set
         if (reg_wdata[ufc_pkg::UFC_CTRL_EN]) begin
            st_next.trig =
               reg_wdata[ufc_pkg::UFC_CTRL_TRIG_HI:ufc_pkg::UFC_CTRL_TRIG_LO];
            st_next.mode = reg_wdata[ufc_pkg::UFC_CTRL_MODE];
            st_next.tx_flush = reg_wdata[ufc_pkg::UFC_CTRL_TX_FLUSH];
            st_next.rx_flush = reg_wdata[ufc_pkg::UFC_CTRL_RX_FLUSH];
         end
      end

      // read data, valid only in the cycle after the strobe
      st_next.rdata = 8'h00;
      if (reg_rd) begin
         unique case (reg_addr)
            ufc_pkg::UFC_OFS_DATA: begin
               st_next.rdata = rxf.empty ? 8'h00 : rxf.head;
            end
            ufc_pkg::UFC_OFS_CTRL: begin
               st_next.rdata = ctrl_view;
            end
            ufc_pkg::UFC_OFS_RX_LEVEL: begin
               st_next.rdata = 8'(rxf.count);
            end
            ufc_pkg::UFC_OFS_TX_LEVEL: begin
               st_next.rdata = 8'(txf.count);
            end
            default: begin
               st_next.rdata = 8'h00;
            end
         endcase
      end

      // transmit ready pin
      if (block_mode) begin
         // high only with every location taken
         st_next.tx_rdy_n = txf.full;
      end else begin
         // low while nothing waits to go
         st_next.tx_rdy_n = !txf.empty;
      end

      // block-mode receive ready tracker
      unique case (st_reg.rx_st)
         ufc_pkg::UFC_RX_IDLE: begin
            if (at_trigger || rx_timeout) begin
               st_next.rx_st = ufc_pkg::UFC_RX_ARMED;
            end
         end
         ufc_pkg::UFC_RX_ARMED: begin
            if (rxf.empty && !rx_timeout) begin
               st_next.rx_st = ufc_pkg::UFC_RX_IDLE;
            end
         end
         default: begin
            st_next.rx_st = ufc_pkg::UFC_RX_IDLE;
         end
      endcase

      if (block_mode) begin
         st_next.rx_rdy_n = (st_next.rx_st == ufc_pkg::UFC_RX_IDLE);
      end else begin
         // low while a character is held
         st_next.rx_rdy_n = rxf.empty;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st_reg.trig <= ufc_pkg::UFC_CTRL_RESET[7:6];
         st_reg.mode <= ufc_pkg::UFC_CTRL_RESET[3];
         st_reg.en <= ufc_pkg::UFC_CTRL_RESET[0];
         st_reg.tx_flush <= ufc_pkg::UFC_CTRL_RESET[2];
         st_reg.rx_flush <= ufc_pkg::UFC_CTRL_RESET[1];
         st_reg.rdata <= 8'h00;
         st_reg.rx_st <= ufc_pkg::UFC_RX_IDLE;
         st_reg.tx_rdy_n <= ufc_pkg::UFC_TX_READY_N_RESET;
         st_reg.rx_rdy_n <= ufc_pkg::UFC_RX_READY_N_RESET;
         st_reg.overrun <= 1'b0;
      end else begin
         st_reg <= st_next;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   sequence ctrl_write_s(logic [7:0] mask);
      ctrl_wr && ((reg_wdata & mask) == mask);
   endsequence

   sequence ctrl_read_s;
      reg_rd && (reg_addr == ufc_pkg::UFC_OFS_CTRL);
   endsequence

   ctrl_unused_zero_a: assert property (
      ctrl_read_s |=> (reg_rdata[5:4] == 2'h0))
      else $error("unused control bits read nonzero");
   flush_selfclear_a: assert property (
      ctrl_read_s |=> (reg_rdata[2:1] == 2'h0))
      else $error("flush bits did not self clear");
   tx_flush_done_a: assert property (
      ctrl_write_s(8'h05) |-> ##2 (txf.count == '0))
      else $error("transmit flush did not empty fifo");
   rx_flush_done_a: assert property (
      ctrl_write_s(8'h03) |-> ##2 (rxf.count == '0))
      else $error("receive flush did not empty fifo");
   write_gated_a: assert property (
      (ctrl_wr && !reg_wdata[0]) |=>
         (st_reg.mode == $past(st_reg.mode)) &&
         (st_reg.trig == $past(st_reg.trig)))
      else $error("control field changed without enable");
   mode_select_a: assert property (
      ctrl_write_s(8'h09) |=> st_reg.mode && st_reg.en)
      else $error("block mode not selected");
   tx_mode0_a: assert property (
      (!block_mode && txf.empty) |=> !tx_ready_n ##1
         (tx_ready_n || $past(txf.empty) || $past(block_mode)))
      else $error("transmit ready wrong in single mode");
   tx_mode1_a: assert property (
      block_mode |=> (tx_ready_n == $past(txf.full)))
      else $error("transmit ready wrong in block mode");
   rx_mode0_a: assert property (
      !block_mode |=> (rx_ready_n == $past(rxf.empty)))
      else $error("receive ready wrong in single mode");
   rx_mode1_a: assert property (
      (block_mode && at_trigger) |=> !rx_ready_n)
      else $error("receive ready not low at trigger");
   rx_mode1_hold_a: assert property (
      (block_mode && $past(block_mode) && !rx_ready_n && !rxf.empty)
         |=> !rx_ready_n)
      else $error("receive ready released before empty");
   one_deep_a: assert property (
      (!st_reg.en && rxf.count != '0 && rx_char_valid && !rxf.pop)
         |=> rx_overrun)
      else $error("holding register accepted a second char");

   en_follows_a: assert property (
      ctrl_wr |=> (st_reg.en == $past(reg_wdata[ufc_pkg::UFC_CTRL_EN])))
      else $error("fifo enable not taken from write");
   fields_take_a: assert property (
      ctrl_write_s(8'h01) |=>
         (st_reg.trig == $past(reg_wdata[7:6])) &&
         (st_reg.mode == $past(reg_wdata[3])))
      else $error("control fields not taken with enable set");
   // a pop or flush beside the push would move the count as well, hiding the accepted character
   fill_past_trig_a: assert property (
      (at_trigger && rx_char_valid && !rxf.full && !rxf.pop && !rxf.flush)
         |=> (rxf.count == $past(rxf.count) + CW'(1)))
      else $error("receive fifo stopped filling at trigger");
   rx_timeout_arm_a: assert property (
      (block_mode && rx_timeout) |=> !rx_ready_n)
      else $error("receive ready not low after timeout");
endmodule

/* pkg/ufc_pkg.sv */
// constants, register map and trigger decode for the uart fifo control block
package ufc_pkg;
   localparam int UFC_DATA_W = 8;
   localparam int UFC_DEPTH = 16;
   localparam int UFC_ADDR_W = 3;
   localparam int UFC_CNT_W = 5;

   // register offsets
   localparam logic [2:0] UFC_OFS_DATA = 3'h0;
   localparam logic [2:0] UFC_OFS_CTRL = 3'h1;
   localparam logic [2:0] UFC_OFS_RX_LEVEL = 3'h2;
   localparam logic [2:0] UFC_OFS_TX_LEVEL = 3'h3;

   // fifo_control field positions
   localparam int UFC_CTRL_EN = 0;
   localparam int UFC_CTRL_RX_FLUSH = 1;
   localparam int UFC_CTRL_TX_FLUSH = 2;
   localparam int UFC_CTRL_MODE = 3;
   localparam int UFC_CTRL_TRIG_LO = 6;
   localparam int UFC_CTRL_TRIG_HI = 7;

   // values after reset
   localparam logic [7:0] UFC_CTRL_RESET = 8'h00;
   localparam logic UFC_TX_READY_N_RESET = 1'b0;
   localparam logic UFC_RX_READY_N_RESET = 1'b1;

   // receive trigger levels in characters
   localparam logic [4:0] UFC_TRIG_1 = 5'h01;
   localparam logic [4:0] UFC_TRIG_4 = 5'h04;
   localparam logic [4:0] UFC_TRIG_8 = 5'h08;
   localparam logic [4:0] UFC_TRIG_14 = 5'h0e;

   // block-mode receive ready state
   typedef enum logic [1:0] {
      UFC_RX_IDLE = 2'b01,
      UFC_RX_ARMED = 2'b10
   } ufc_rx_state_t;

   function automatic logic [4:0] ufc_trig_level(input logic [1:0] sel);
      logic [4:0] lvl;
      lvl = UFC_TRIG_1;
      unique case (sel)
         2'h0: lvl = UFC_TRIG_1;
         2'h1: lvl = UFC_TRIG_4;
         2'h2: lvl = UFC_TRIG_8;
         2'h3: lvl = UFC_TRIG_14;
      endcase
      return lvl;
   endfunction
endpackage

/* pkg/ufc_fifo_if.sv */
// interface between a fifo store and the logic that fills and drains it
`timescale 1ns/1ps
interface ufc_fifo_if #(parameter int W = 8, parameter int D = 16) ();
   localparam int CW = $clog2(D + 1);
   logic push;
   logic [W-1:0] push_data;
   logic pop;
   logic flush;
   logic one_deep;
   logic [W-1:0] head;
   logic [CW-1:0] count;
   logic full;
   logic empty;

   modport store (input push, push_data, pop, flush, one_deep,
                  output head, count, full, empty);
   modport user (output push, push_data, pop, flush, one_deep,
                 input head, count, full, empty);
   modport mon (input count, full, empty, one_deep);
endinterface

/* verilog/ufc_fifo.sv */
// flip-flop fifo store with flush and a one-deep holding-register mode
`timescale 1ns/1ps
module ufc_fifo #(
   parameter int W = 8,
   parameter int D = 16
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // fifo access
   ufc_fifo_if.store f
);
   // pointers wrap naturally, so D must be a power of two
   localparam int AW = $clog2(D);
   localparam int CW = $clog2(D + 1);

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [CW-1:0] cnt;
   } ufc_fifo_st_t;

   ufc_fifo_st_t st_reg;
   ufc_fifo_st_t st_next;
   logic do_push;
   logic do_pop;

   assign f.empty = (st_reg.cnt == '0);
   // holding-register mode takes a single character only
   assign f.full = f.one_deep ? !f.empty : (st_reg.cnt == CW'(D));
   assign f.count = st_reg.cnt;
   assign f.head = st_reg.mem[st_reg.rp];
   assign do_push = f.push && !f.full;
   assign do_pop = f.pop && !f.empty;

   always_comb begin
      st_next = st_reg;
      if (f.flush) begin
         // contents dropped, pointers and count back to zero
         st_next.wp = '0;
         st_next.rp = '0;
         st_next.cnt = '0;
      end else begin
         if (do_push) begin
            st_next.mem[st_reg.wp] = f.push_data;
            st_next.wp = st_reg.wp + AW'(1);
         end
         if (do_pop) begin
            st_next.rp = st_reg.rp + AW'(1);
         end
         if (do_push && !do_pop) begin
            st_next.cnt = st_reg.cnt + CW'(1);
         end else if (do_pop && !do_push) begin
            st_next.cnt = st_reg.cnt - CW'(1);
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   count_bound_a: assert property (
      st_reg.cnt <= CW'(D))
      else $error("fifo count above depth");
   flush_empties_a: assert property (
      f.flush |=> (st_reg.cnt == '0) && f.empty)
      else $error("flush left characters behind");
endmodule

/* verilog/ufc_rx_trigger.sv */
// receive trigger compare and receive-data interrupt condition
`timescale 1ns/1ps
module ufc_rx_trigger (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // settings
   input wire logic fifo_en,
   input wire logic [1:0] rx_trigger_select,
   input wire logic rx_int_enable,
   // receive fifo state
   ufc_fifo_if.mon rxf,
   // results
   output logic at_trigger,
   output logic rx_data_int
);
   typedef struct packed {
      logic irq;
   } ufc_trig_st_t;

   ufc_trig_st_t st_reg;
   ufc_trig_st_t st_next;
   logic [4:0] level;

   assign level = ufc_pkg::ufc_trig_level(rx_trigger_select);
   assign at_trigger = (rxf.count >= level);
   assign rx_data_int = st_reg.irq;

   always_comb begin
      st_next = st_reg;
      if (fifo_en) begin
         st_next.irq = rx_int_enable && at_trigger;
      end else begin
         st_next.irq = rx_int_enable && !rxf.empty;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   int_raise_a: assert property (
      (fifo_en && rx_int_enable && rxf.count == level) |=> rx_data_int)
      else $error("receive interrupt missing at trigger level");
   int_withdraw_a: assert property (
      (fifo_en && rxf.count < level) |=> !rx_data_int)
      else $error("receive interrupt held below trigger level");
endmodule

/* tb/ufc_shifter_model.sv */
// shifter stand-in on the far side of the transmit and receive fifos
`timescale 1ns/1ps
module ufc_shifter_model (
   // clock
   input wire logic sys_clk,
   // transmit side
   input wire logic [7:0] tx_char,
   input wire logic tx_char_valid,
   input wire logic drain,
   output logic tx_char_take,
   output logic [7:0] last_taken,
   // receive side
   output logic [7:0] rx_char,
   output logic rx_char_valid,
   output logic rx_timeout
);
   initial begin
      tx_char_take = 1'b0;
      last_taken = 8'h00;
      rx_char = 8'ha5;
      rx_char_valid = 1'b0;
      rx_timeout = 1'b0;
   end

   logic seen_valid = 1'b0;
   logic [7:0] seen_char = 8'h00;

   // design outputs captured mid-cycle, clear of the edge that moves them
   always @(negedge sys_clk) begin
      seen_valid <= tx_char_valid;
      seen_char <= tx_char;
   end

   // slow shifter: takes at most every other cycle
   always @(posedge sys_clk) begin
      tx_char_take <= drain & seen_valid & ~tx_char_take;
      if (tx_char_take && seen_valid)
         last_taken <= seen_char;
   end

   // idle data shows the inverse so a stale byte never passes
   task automatic send(input logic [7:0] c);
      @(posedge sys_clk);
      rx_char <= c;
      rx_char_valid <= 1'b1;
      @(posedge sys_clk);
      rx_char_valid <= 1'b0;
      rx_char <= ~c;
   endtask

   task automatic timeout();
      @(posedge sys_clk);
      rx_timeout <= 1'b1;
      @(posedge sys_clk);
      rx_timeout <= 1'b0;
   endtask
endmodule

/* tb/uart_fifo_control_dma_ready_test.sv */
// self-checking bench for the uart fifo control block
`timescale 1ns/1ps
module uart_fifo_control_dma_ready_test;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [2:0] reg_addr = 3'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic rx_int_enable = 1'b1;
   logic drain = 1'b0;
   logic [7:0] reg_rdata, tx_char, rx_char, last_taken;
   logic tx_char_valid, tx_char_take, rx_char_valid, rx_timeout;
   logic rx_overrun, rx_data_int, tx_ready_n, rx_ready_n;
   logic prev_rd = 1'b0;
   logic [7:0] exp_q[$];
   logic [7:0] rx_q[$];
   int n_fail = 0;
   int num_checks = 0;
   int cycles = 0;
   int ovr_seen = 0;
   int lvl;

   initial begin
      forever #2 sys_clk = ~sys_clk;
   end

   ufc_top u_dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .tx_char(tx_char),
      .tx_char_valid(tx_char_valid), .tx_char_take(tx_char_take),
      .rx_char(rx_char), .rx_char_valid(rx_char_valid),
      .rx_timeout(rx_timeout), .rx_overrun(rx_overrun),
      .rx_int_enable(rx_int_enable), .rx_data_int(rx_data_int),
      .tx_ready_n(tx_ready_n), .rx_ready_n(rx_ready_n));

   ufc_shifter_model u_sh (.sys_clk(sys_clk), .tx_char(tx_char),
      .tx_char_valid(tx_char_valid), .drain(drain),
      .tx_char_take(tx_char_take), .last_taken(last_taken),
      .rx_char(rx_char), .rx_char_valid(rx_char_valid),
      .rx_timeout(rx_timeout));

   task automatic end_of_test();
      if (n_fail == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic check(input string what, input logic [7:0] e,
                        input logic [7:0] g);
      num_checks++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", what, e, g);
      end
   endtask

   always @(posedge sys_clk) begin
      prev_rd <= reg_rd;
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         end_of_test();
      end
   end

   // read data and overrun pulses looked at mid-cycle, where they stand;
   // oldest note first
   always @(negedge sys_clk) begin
      if (rx_overrun === 1'b1)
         ovr_seen++;
      if (prev_rd) begin
         if (exp_q.size() == 0)
            check("read note", 8'h00, 8'hxx);
         else
            check("reg_rdata", exp_q.pop_front(), reg_rdata);
      end
   end

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      exp_q.push_back(e);
      @(posedge sys_clk);
      reg_rd <= 1'b0;
   endtask

   task automatic put_rx(input int n);
      logic [7:0] c;
      repeat (n) begin
         c = 8'($urandom);
         rx_q.push_back(c);
         u_sh.send(c);
      end
   endtask

   task automatic pop_rx();
      rd(ufc_pkg::UFC_OFS_DATA, rx_q.pop_front());
   endtask

   // pins lag the strobe by two cycles, three when the strobe writes a flush bit
   task automatic pins(input logic etx, input logic erx);
      repeat (4) @(posedge sys_clk);
      // never in the time step of the edge that moves the pins
      @(negedge sys_clk);
      check("tx_ready_n", {7'h00, etx}, {7'h00, tx_ready_n});
      check("rx_ready_n", {7'h00, erx}, {7'h00, rx_ready_n});
   endtask

   initial begin
      void'($urandom(32'h4f9ed711));
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      rd(ufc_pkg::UFC_OFS_CTRL, 8'h00);
      pins(1'b0, 1'b1);
      wr(ufc_pkg::UFC_OFS_CTRL, 8'hc8);
      rd(ufc_pkg::UFC_OFS_CTRL, 8'h00);
      // software sets the enable with every other field
      wr(ufc_pkg::UFC_OFS_CTRL, 8'hff);
      rd(ufc_pkg::UFC_OFS_CTRL, 8'hc9);
      for (int s = 0; s < 4; s++) begin
         lvl = (s == 0) ? 1 : (s == 1) ? 4 : (s == 2) ? 8 : 14;
         wr(ufc_pkg::UFC_OFS_CTRL, {s[1:0], 6'h0f});
         rx_q.delete();
         put_rx(lvl - 1);
         pins(1'b0, 1'b1);
         check("rx_data_int", 8'h00, {7'h00, rx_data_int});
         put_rx(1);
         pins(1'b0, 1'b0);
         check("rx_data_int", 8'h01, {7'h00, rx_data_int});
         pop_rx();
         pins(1'b0, lvl == 1);
         check("rx_data_int", 8'h00, {7'h00, rx_data_int});
         while (rx_q.size() > 0)
            pop_rx();
         pins(1'b0, 1'b1);
      end
      // fill past full at trigger 14: the seventeenth is dropped
      put_rx(16);
      u_sh.send(8'h5a);
      pins(1'b0, 1'b0);
      check("overruns", 8'h01, 8'(ovr_seen));
      check("rx_data_int", 8'h01, {7'h00, rx_data_int});
      @(posedge sys_clk);
      rx_int_enable <= 1'b0;
      pins(1'b0, 1'b0);
      check("rx_data_int", 8'h00, {7'h00, rx_data_int});
      @(posedge sys_clk);
      rx_int_enable <= 1'b1;
      rd(ufc_pkg::UFC_OFS_RX_LEVEL, 8'h10);
      wr(ufc_pkg::UFC_OFS_CTRL, 8'hcb);
      rx_q.delete();
      rd(ufc_pkg::UFC_OFS_RX_LEVEL, 8'h00);
      pins(1'b0, 1'b1);
      put_rx(1);
      u_sh.timeout();
      pins(1'b0, 1'b0);
      pop_rx();
      pins(1'b0, 1'b1);
      repeat (15)
         wr(ufc_pkg::UFC_OFS_DATA, 8'($urandom));
      pins(1'b0, 1'b1);
      wr(ufc_pkg::UFC_OFS_DATA, 8'h3c);
      pins(1'b1, 1'b1);
      wr(ufc_pkg::UFC_OFS_CTRL, 8'hcd);
      rd(ufc_pkg::UFC_OFS_TX_LEVEL, 8'h00);
      pins(1'b0, 1'b1);
      wr(ufc_pkg::UFC_OFS_CTRL, 8'h01);
      pins(1'b0, 1'b1);
      wr(ufc_pkg::UFC_OFS_DATA, 8'h96);
      pins(1'b1, 1'b1);
      @(posedge sys_clk);
      drain <= 1'b1;
      pins(1'b0, 1'b1);
      check("last_taken", 8'h96, last_taken);
      drain <= 1'b0;
      put_rx(1);
      pins(1'b0, 1'b0);
      pop_rx();
      pins(1'b0, 1'b1);
      // fifos off: a single holding place each way
      wr(ufc_pkg::UFC_OFS_CTRL, 8'h00);
      rd(ufc_pkg::UFC_OFS_CTRL, 8'h00);
      put_rx(1);
      u_sh.send(8'hc3);
      pins(1'b0, 1'b0);
      check("overruns", 8'h02, 8'(ovr_seen));
      check("rx_data_int", 8'h01, {7'h00, rx_data_int});
      pop_rx();
      wr(ufc_pkg::UFC_OFS_DATA, 8'h11);
      wr(ufc_pkg::UFC_OFS_DATA, 8'h22);
      rd(ufc_pkg::UFC_OFS_TX_LEVEL, 8'h01);
      pins(1'b1, 1'b1);
      rd(3'h5, 8'h00);
      wr(3'h6, 8'hff);
      rd(ufc_pkg::UFC_OFS_CTRL, 8'h00);
      repeat (4) @(posedge sys_clk);
      end_of_test();
   end
endmodule
